//--- bench/testbench.sv
// Self-checking bench of the windowed watchdog unit
`timescale 1ns/1ps
`include "wwd_map.vh"

module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, halt = 1'b0, guard = 1'b0;
    logic [14:0] nvm = 15'h0121; // Disabled, window 1, period 2, offset 1
    wire hsel, hwrite, hready, hresp, sys_rst, irq;
    wire [1:0] htrans;
    wire [31:0] haddr, hwdata, hrdata;
    int num_errors = 0, num_checks = 0, n, k, rst_seen = 0;
    logic [31:0] q;

    always #5 clk = ~clk;
    // Slow count clock runs before any use of the unit
    always #40 slow = ~slow;
    // Count system reset pulses mid-cycle, so a snapshot at an edge never races them
    always @(negedge clk) if (sys_rst === 1'b1) rst_seen <= rst_seen + 1;

    wwd_ahb_master i_bus (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    wwd_top i_dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .SLOW_COUNT_CLOCK(slow),
        .DEBUG_HALT(halt), .PERIPHERAL_WRITE_GUARD(guard), .NVM_ENABLE(nvm[14]),
        .NVM_STICKY_RUN(nvm[13]), .NVM_WEN(nvm[12]), .NVM_WINDOW(nvm[11:8]),
        .NVM_PERIOD(nvm[7:4]), .NVM_EW_OFFSET(nvm[3:0]), .SYS_RESET(sys_rst),
        .EARLY_WARN_IRQ(irq));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        i_bus.xfer(1'b1, {22'h0, idx, 2'b00}, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        i_bus.xfer(1'b0, {22'h0, idx, 2'b00}, 32'h0, q);
        chk(q, exp);
    endtask
    // Bounded wait for irq or reset; sampled mid-cycle to avoid edge races
    task automatic wait_sig(input bit want_irq, input int lim);
        n = 0;
        while (n < lim && (want_irq ? irq : sys_rst) !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    // Count resets over a quiet span
    task automatic quiet(input int cyc, input int exp);
        k = rst_seen;
        repeat (cyc) @(posedge clk);
        chk(rst_seen - k, exp);
    endtask
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog of the bench itself
    initial begin
        #100us;
        num_errors++;
        close_out();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`WWD_IDX_CTRL, 32'h0);
        rd(`WWD_IDX_CONFIG, 32'h12);
        rd(`WWD_IDX_WARN_CTRL, 32'h1);
        rd(`WWD_IDX_IRQ_SET, 32'h0);
        rd(8'h03, 32'h0);
        rd(`WWD_IDX_CLEAR, 32'h0);
        // Guard blocks configuration writes
        guard <= 1'b1;
        wr(`WWD_IDX_CONFIG, 32'h33);
        guard <= 1'b0;
        rd(`WWD_IDX_CONFIG, 32'h12);
        // Normal mode: warning at 8 slow edges, time-out at 16
        wr(`WWD_IDX_CONFIG, 32'h01);
        wr(`WWD_IDX_WARN_CTRL, 32'h00);
        wr(`WWD_IDX_IRQ_SET, 32'h1);
        wr(`WWD_IDX_CTRL, 32'h02);
        rd(`WWD_IDX_STATUS, 32'h80);
        wr(`WWD_IDX_CONFIG, 32'h05);
        rd(`WWD_IDX_CONFIG, 32'h01);
        wait_sig(1'b1, 400);
        chk(n < 400, 1);
        wait_sig(1'b0, 400);
        chk(n >= 58 && n <= 68, 1);
        // Key clears keep it quiet
        k = rst_seen;
        repeat (6) begin
            wr(`WWD_IDX_CLEAR, 32'hA5);
            repeat (80) @(posedge clk);
        end
        chk(rst_seen - k, 0);
        // Flag is set here; disabling the interrupt alone must drop the request
        @(negedge clk);
        chk(irq, 1);
        @(posedge clk);
        wr(`WWD_IDX_IRQ_CLR, 32'h1);
        @(negedge clk);
        chk(irq, 0);
        @(posedge clk);
        // Flag register stays writable under the guard
        guard <= 1'b1;
        wr(`WWD_IDX_IRQ_FLAG, 32'h1);
        guard <= 1'b0;
        rd(`WWD_IDX_IRQ_FLAG, 32'h0);
        wr(`WWD_IDX_CLEAR, 32'h5A);
        quiet(8, 1);
        // Disable with a held configuration write
        wr(`WWD_IDX_CTRL, 32'h00);
        wr(`WWD_IDX_CONFIG, 32'h10);
        repeat (10) @(posedge clk);
        rd(`WWD_IDX_CONFIG, 32'h10);
        quiet(300, 0);
        // Window mode: closed 16 edges, open 8 edges
        wr(`WWD_IDX_IRQ_FLAG, 32'h1);
        wr(`WWD_IDX_IRQ_SET, 32'h1);
        wr(`WWD_IDX_CTRL, 32'h06);
        wr(`WWD_IDX_CLEAR, 32'hA5);
        quiet(10, 1);
        wait_sig(1'b1, 600);
        chk(n < 600, 1);
        wr(`WWD_IDX_IRQ_FLAG, 32'h1);
        wr(`WWD_IDX_CLEAR, 32'hA5);
        quiet(100, 0);
        // Debug halt freezes the count
        halt <= 1'b1;
        quiet(400, 0);
        halt <= 1'b0;
        // Sticky run: config frozen, window bit free, enable ignored
        wr(`WWD_IDX_CTRL, 32'h00);
        repeat (10) @(posedge clk);
        wr(`WWD_IDX_CTRL, 32'h80);
        wr(`WWD_IDX_CONFIG, 32'h00);
        rd(`WWD_IDX_CONFIG, 32'h10);
        wr(`WWD_IDX_CTRL, 32'h04);
        i_bus.xfer(1'b0, 32'h0, 32'h0, q);
        chk(q & 32'h84, 32'h84);
        wait_sig(1'b0, 600);
        chk(n < 600, 1);
        chk(hresp, 0);
        close_out();
    end
endmodule

//--- bench/wwd_ahb_master.sv
// Bus master standing in for processor software
`timescale 1ns/1ps

module wwd_ahb_master (
    // Clock
    input wire clk,
    // Master outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata,
    // Slave answer
    input wire hready,
    input wire [31:0] hrdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end

    // Ready seen at the falling edge is what the next rising edge samples
    task automatic wait_rdy(output logic [31:0] q);
        @(negedge clk);
        while (hready !== 1'b1) @(negedge clk);
        q = hrdata;
        @(posedge clk);
    endtask

    // One single word transfer; called just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy(q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(q);
    endtask
endmodule

//--- bench/wwd_top_assertions.sv
// Port-level checks of the windowed watchdog unit
`timescale 1ns/1ps

module wwd_checker (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Bus side
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire HREADYOUT,
    input wire HRESP,
    input wire [31:0] HRDATA,
    // Control and results
    input wire DEBUG_HALT,
    input wire PERIPHERAL_WRITE_GUARD,
    input wire SYS_RESET,
    input wire EARLY_WARN_IRQ
);
    // ----------------------------------------------------------------
    // Common clocking
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Accepted address phases
    wire rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
    wire wr_go = HSEL && HTRANS[1] && HREADY && HWRITE;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("response not OKAY");
    a_sysrst_pulse: assert property (SYS_RESET |=> !SYS_RESET)
        else $error("system reset longer than one cycle");
    a_stall_bound: assert property (!HREADYOUT |-> ##[1:4] HREADYOUT)
        else $error("bus stalled too long");
    a_rdata_upper: assert property (HRDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_clear_reads: assert property (rd_go && HADDR == 32'h20 |=> HRDATA == 32'h0)
        else $error("clear register read not zero");
    a_resv_reads: assert property (rd_go && HADDR == 32'h0C |=> HRDATA == 32'h0)
        else $error("reserved read not zero");
    a_halt_quiet: assert property ((DEBUG_HALT && !HSEL)[*6] |-> !SYS_RESET)
        else $error("reset while halted");
    a_irq_clr: assert property ((wr_go && HADDR == 32'h10) ##1
        (HWDATA[0] && HREADYOUT && !PERIPHERAL_WRITE_GUARD) |=> !EARLY_WARN_IRQ)
        else $error("interrupt stays after disable");

    // Main scenarios reached
    c_reset: cover property (SYS_RESET);
    c_irq: cover property (EARLY_WARN_IRQ);
    c_stall: cover property (!HREADYOUT);
endmodule

bind wwd_top wwd_checker i_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .DEBUG_HALT(DEBUG_HALT),
    .PERIPHERAL_WRITE_GUARD(PERIPHERAL_WRITE_GUARD), .SYS_RESET(SYS_RESET),
    .EARLY_WARN_IRQ(EARLY_WARN_IRQ));

//--- logic/wwd_counter.v
// Slow-clock edge detector and time-out counter of the watchdog unit
`timescale 1ns/1ps

module wwd_counter (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Slow count clock, sampled as a plain input
    input wire SLOW_CLK,
    // Control from the main block
    input wire RUN,
    input wire HALT,
    input wire RESTART,
    // Count state
    output wire TICK,
    output wire [15:0] COUNT
);

    reg slow_prev_reg; // Previous slow clock level
    reg [15:0] count_reg; // Slow cycles counted in this period

    // ----------------------------------------------------------------
    // Rising edge of the slow clock
    // ----------------------------------------------------------------
    // Halted in debug, no edge counts at all
    assign TICK = SLOW_CLK & ~slow_prev_reg & RUN & ~HALT;
    assign COUNT = count_reg;

    // Edge history; starts high so a high level at release is no edge
    always @(posedge CLK) begin
        if (RST) begin
            slow_prev_reg <= 1'b1;
        end else begin
            slow_prev_reg <= SLOW_CLK;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Restart wins over a tick in the same cycle
    always @(posedge CLK) begin
        if (RST || !RUN || RESTART) begin
            count_reg <= 16'h0000;
        end else if (TICK) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

endmodule

//--- logic/wwd_map.vh
// Register map, field positions, reset values and timing counts of the watchdog unit
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WWD_IDX_CTRL 8'h00
`define WWD_IDX_CONFIG 8'h01
`define WWD_IDX_WARN_CTRL 8'h02
`define WWD_IDX_IRQ_CLR 8'h04
`define WWD_IDX_IRQ_SET 8'h05
`define WWD_IDX_IRQ_FLAG 8'h06
`define WWD_IDX_STATUS 8'h07
`define WWD_IDX_CLEAR 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WWD_CTRL_ENABLE_BIT 1
`define WWD_CTRL_WEN_BIT 2
`define WWD_CTRL_STICKY_BIT 7
`define WWD_WARN_BIT 0
`define WWD_STATUS_SYNC_BIT 7
`define WWD_PERIOD_LSB 0
`define WWD_WINDOW_LSB 4

// ----------------------------------------------------------------
// Reset values, key and lengths
// ----------------------------------------------------------------
`define WWD_RST_ZERO4 4'h0
`define WWD_RST_IE 1'b0
`define WWD_CLEAR_KEY 8'hA5
`define WWD_MIN_LEN 16'h0008
`define WWD_MAX_CODE 4'hB
`define WWD_MAX_LEN 16'h4000

// ----------------------------------------------------------------
// Timing counts (bus clock cycles)
// ----------------------------------------------------------------
`define WWD_SYNC_CYCLES 3'h3

`endif

//--- logic/wwd_top.v
// Windowed watchdog unit: AHB-Lite registers, sync, window control and early warning
`timescale 1ns/1ps
`include "wwd_map.vh"

// Overview of operation
// - Stopped when disabled; window bit picks mode
// - Protected writes discarded while enabled
// - Protected writes during disabling held, then done
// - Power-on loads settings from user row
// - Enable starts; disable only without sticky run
// - Normal mode: period expiry resets system
// - Key write restarts the period
// - Wrong clear value resets system immediately
// - Period field selects twelve lengths
// - Early warning off by default; set/clear
// - Normal mode early warning at offset
// - Window mode: clear only in open window
// - Closed from window field, open from period
// - Window mode warning when window opens
// - Sticky run keeps counting until power-on
// - Sticky run freezes config and warning control
// - Sticky run still allows window bit writes
// - Debug halt stops counting
// - Write guard covers all but flag register
// - Slow count clock separate, control and clear writes synchronized
// - Offset counts slow cycles from period start
// - Interrupt held while flag set and enabled
// - Sync busy flag; further synced writes stall
module wwd_top (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // AHB-Lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output wire HRESP,
    output wire [31:0] HRDATA,
    // Slow count clock and debug halt
    input wire SLOW_COUNT_CLOCK,
    input wire DEBUG_HALT,
    // Peripheral write guard
    input wire PERIPHERAL_WRITE_GUARD,
    // User row settings
    input wire NVM_ENABLE,
    input wire NVM_STICKY_RUN,
    input wire NVM_WEN,
    input wire [3:0] NVM_WINDOW,
    input wire [3:0] NVM_PERIOD,
    input wire [3:0] NVM_EW_OFFSET,
    // Results
    output wire SYS_RESET,
    output wire EARLY_WARN_IRQ
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg dp_valid_reg; // Data phase pending
    reg dp_write_reg; // Pending phase is a write
    reg [7:0] dp_idx_reg; // Register index of pending phase
    reg [31:0] hrdata_reg; // Read data, captured at address phase
    reg nvm_load_reg; // First cycle after reset loads user row
    reg enable_reg; // Software view of enable
    reg enable_eff_reg; // Enable as seen by the counter
    reg wen_reg; // Window mode enable
    reg sticky_run_bit_reg; // Sticky always-run bit
    reg [3:0] timeout_period_sel_reg; // Open or normal period code
    reg [3:0] window_sel_reg; // Closed window code
    reg [3:0] early_warn_offset_reg; // Early warning offset code
    reg warn_ie_reg; // Early warning interrupt enable
    reg warn_flag_reg; // Early warning flag
    reg [2:0] sync_cnt_reg; // Sync countdown, busy while non-zero
    reg clr_pend_reg; // Clear write waiting for sync
    reg [7:0] clr_data_reg; // Value written to clear
    reg hold_valid_reg; // Held protected write
    reg [7:0] hold_idx_reg; // Index of held write
    reg [7:0] hold_data_reg; // Data of held write
    reg phase_open_reg; // Window mode: open window running
    reg sys_reset_reg; // System reset pulse
    wire addr_take;
    wire sync_pending;
    wire sync_done;
    wire sync_need;
    wire disabling;
    wire hold_apply;
    wire stall;
    wire bus_wr;
    wire wr_go;
    wire wr_from_hold;
    wire [7:0] wr_idx;
    wire [7:0] wr_data;
    wire running;
    wire tick;
    wire [15:0] count;
    wire [15:0] count_inc;
    wire [15:0] cur_len;
    wire hit;
    wire warn_hit;
    wire timeout;
    wire open_start;
    wire clr_fire;
    wire valid_clr;
    wire bad_clr;
    wire early_clr;
    wire reset_now;
    wire restart;
    wire [7:0] ctrl_view;

    // ----------------------------------------------------------------
    // Length decoder
    // ----------------------------------------------------------------
    // Codes above eleven are reserved; they clamp to the longest length
    function [15:0] len_of;
        input [3:0] code;
        begin
            if (code > `WWD_MAX_CODE) begin
                len_of = `WWD_MAX_LEN;
            end else begin
                len_of = `WWD_MIN_LEN << code;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    assign addr_take = HSEL & HTRANS[1] & HREADY;
    assign sync_pending = (sync_cnt_reg != 3'h0);
    assign sync_done = (sync_cnt_reg == 3'h1);
    assign sync_need = (dp_idx_reg == `WWD_IDX_CTRL) | (dp_idx_reg == `WWD_IDX_CLEAR);
    // Disabling: software wrote zero but the counter side still runs
    assign disabling = ~enable_reg & enable_eff_reg;
    assign hold_apply = hold_valid_reg & ~disabling;
    // A synced write during busy waits; the held write owns its cycle
    assign stall = dp_valid_reg & dp_write_reg
        & ((sync_need & sync_pending) | hold_apply);
    assign HREADYOUT = ~stall;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_reg;
    // Guard blocks every write except the flag register
    assign bus_wr = dp_valid_reg & dp_write_reg & ~stall
        & (~PERIPHERAL_WRITE_GUARD | (dp_idx_reg == `WWD_IDX_IRQ_FLAG));
    assign wr_from_hold = hold_apply;
    assign wr_go = bus_wr | hold_apply;
    assign wr_idx = wr_from_hold ? hold_idx_reg : dp_idx_reg;
    assign wr_data = wr_from_hold ? hold_data_reg : HWDATA[7:0];
    assign ctrl_view = {sticky_run_bit_reg, 4'h0, wen_reg, enable_reg, 1'b0};

    // Address phase capture and read data
    always @(posedge CLK) begin
        if (RST) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_idx_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else if (HREADYOUT) begin
            dp_valid_reg <= addr_take;
            dp_write_reg <= HWRITE;
            // Anything above the map decodes to an unmapped index
            dp_idx_reg <= (HADDR[31:10] != 22'h000000) ? 8'hFF : HADDR[9:2];
            hrdata_reg <= 32'h00000000;
            if (addr_take && !HWRITE && HADDR[31:10] == 22'h000000) begin
                case (HADDR[9:2])
                    `WWD_IDX_CTRL: hrdata_reg <= {24'h000000, ctrl_view};
                    `WWD_IDX_CONFIG: hrdata_reg <= {24'h000000, window_sel_reg,
                        timeout_period_sel_reg};
                    `WWD_IDX_WARN_CTRL: hrdata_reg <= {28'h0000000, early_warn_offset_reg};
                    `WWD_IDX_IRQ_CLR: hrdata_reg <= {31'h00000000, warn_ie_reg};
                    `WWD_IDX_IRQ_SET: hrdata_reg <= {31'h00000000, warn_ie_reg};
                    `WWD_IDX_IRQ_FLAG: hrdata_reg <= {31'h00000000, warn_flag_reg};
                    `WWD_IDX_STATUS: hrdata_reg <= {24'h000000, sync_pending, 7'h00};
                    default: hrdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Control and configuration registers
    // ----------------------------------------------------------------
    // Reset takes constants; the user row is loaded on the first clock after
    always @(posedge CLK) begin
        if (RST) begin
            nvm_load_reg <= 1'b1;
            enable_reg <= 1'b0;
            wen_reg <= 1'b0;
            sticky_run_bit_reg <= 1'b0;
            timeout_period_sel_reg <= `WWD_RST_ZERO4;
            window_sel_reg <= `WWD_RST_ZERO4;
            early_warn_offset_reg <= `WWD_RST_ZERO4;
            warn_ie_reg <= `WWD_RST_IE;
            hold_valid_reg <= 1'b0;
            hold_idx_reg <= 8'h00;
            hold_data_reg <= 8'h00;
        end else if (nvm_load_reg) begin
            nvm_load_reg <= 1'b0;
            enable_reg <= NVM_ENABLE;
            wen_reg <= NVM_WEN;
            sticky_run_bit_reg <= NVM_STICKY_RUN;
            timeout_period_sel_reg <= NVM_PERIOD;
            window_sel_reg <= NVM_WINDOW;
            early_warn_offset_reg <= NVM_EW_OFFSET;
        end else begin
            if (hold_apply) begin
                hold_valid_reg <= 1'b0;
            end
            if (wr_go) begin
                case (wr_idx)
                    `WWD_IDX_CTRL: begin
                        if (sticky_run_bit_reg) begin
                            // Only the window bit moves while sticky run is set
                            wen_reg <= wr_data[`WWD_CTRL_WEN_BIT];
                        end else begin
                            if (!wr_from_hold) begin
                                enable_reg <= wr_data[`WWD_CTRL_ENABLE_BIT];
                            end
                            if (!enable_reg && disabling && !wr_from_hold) begin
                                hold_valid_reg <= 1'b1;
                                hold_idx_reg <= wr_idx;
                                hold_data_reg <= wr_data;
                            end else if (!enable_reg) begin
                                // Protected bits, discarded while enabled
                                wen_reg <= wr_data[`WWD_CTRL_WEN_BIT];
                                if (wr_data[`WWD_CTRL_STICKY_BIT]) begin
                                    sticky_run_bit_reg <= 1'b1;
                                end
                            end
                        end
                    end
                    `WWD_IDX_CONFIG, `WWD_IDX_WARN_CTRL: begin
                        if (!sticky_run_bit_reg && !enable_reg) begin
                            if (disabling && !wr_from_hold) begin
                                hold_valid_reg <= 1'b1;
                                hold_idx_reg <= wr_idx;
                                hold_data_reg <= wr_data;
                            end else if (wr_idx == `WWD_IDX_CONFIG) begin
                                timeout_period_sel_reg <= wr_data[`WWD_PERIOD_LSB +: 4];
                                window_sel_reg <= wr_data[`WWD_WINDOW_LSB +: 4];
                            end else begin
                                early_warn_offset_reg <= wr_data[3:0];
                            end
                        end
                    end
                    `WWD_IDX_IRQ_CLR: begin
                        if (wr_data[`WWD_WARN_BIT]) begin
                            warn_ie_reg <= 1'b0;
                        end
                    end
                    `WWD_IDX_IRQ_SET: begin
                        if (wr_data[`WWD_WARN_BIT]) begin
                            warn_ie_reg <= 1'b1;
                        end
                    end
                    default: begin
                        // Flag, clear and read-only indices handled elsewhere
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Synchronization of control and clear writes
    // ----------------------------------------------------------------
    // Fixed countdown stands in for the crossing; busy shows at once
    always @(posedge CLK) begin
        if (RST) begin
            sync_cnt_reg <= 3'h0;
            enable_eff_reg <= 1'b0;
            clr_pend_reg <= 1'b0;
            clr_data_reg <= 8'h00;
        end else if (nvm_load_reg) begin
            enable_eff_reg <= NVM_ENABLE;
        end else begin
            if (bus_wr && sync_need) begin
                sync_cnt_reg <= `WWD_SYNC_CYCLES;
            end else if (sync_pending) begin
                sync_cnt_reg <= sync_cnt_reg - 3'h1;
            end
            if (sync_done) begin
                // Sticky run ignores a stop request
                enable_eff_reg <= enable_reg | sticky_run_bit_reg;
                clr_pend_reg <= 1'b0;
            end
            if (bus_wr && dp_idx_reg == `WWD_IDX_CLEAR) begin
                clr_pend_reg <= 1'b1;
                clr_data_reg <= HWDATA[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter and window sequence
    // ----------------------------------------------------------------
    assign running = enable_eff_reg | sticky_run_bit_reg;
    assign count_inc = count + 16'h0001;
    // Closed part takes the window field, open part the period field
    assign cur_len = (wen_reg && !phase_open_reg) ? len_of(window_sel_reg)
        : len_of(timeout_period_sel_reg);
    assign hit = tick & (count_inc == cur_len);
    assign warn_hit = tick & ~wen_reg & (count_inc == len_of(early_warn_offset_reg));
    assign timeout = hit & (~wen_reg | phase_open_reg);
    assign open_start = hit & wen_reg & ~phase_open_reg;
    assign clr_fire = sync_done & clr_pend_reg;
    assign valid_clr = clr_fire & (clr_data_reg == `WWD_CLEAR_KEY);
    assign bad_clr = clr_fire & (clr_data_reg != `WWD_CLEAR_KEY);
    assign early_clr = valid_clr & wen_reg & ~phase_open_reg;
    assign reset_now = running & (timeout | bad_clr | early_clr);
    assign restart = open_start | valid_clr | reset_now;

    wwd_counter u_counter (
        .CLK(CLK),
        .RST(RST),
        .SLOW_CLK(SLOW_COUNT_CLOCK),
        .RUN(running),
        .HALT(DEBUG_HALT),
        .RESTART(restart),
        .TICK(tick),
        .COUNT(count)
    );

    // Window phase and reset pulse
    always @(posedge CLK) begin
        if (RST) begin
            phase_open_reg <= 1'b0;
            sys_reset_reg <= 1'b0;
        end else begin
            sys_reset_reg <= reset_now;
            if (!running || !wen_reg || valid_clr || reset_now) begin
                phase_open_reg <= 1'b0;
            end else if (open_start) begin
                phase_open_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Early warning flag and interrupt
    // ----------------------------------------------------------------
    // A new warning beats a clear in the same cycle
    always @(posedge CLK) begin
        if (RST) begin
            warn_flag_reg <= 1'b0;
        end else if (running && (warn_hit || open_start)) begin
            warn_flag_reg <= 1'b1;
        end else if (wr_go && wr_idx == `WWD_IDX_IRQ_FLAG && wr_data[`WWD_WARN_BIT]) begin
            warn_flag_reg <= 1'b0;
        end
    end

    assign EARLY_WARN_IRQ = warn_flag_reg & warn_ie_reg;
    assign SYS_RESET = sys_reset_reg;

endmodule
